// ### rtl/fcs_pkg.sv
// Constants and types of the flash command sequencer host
package fcs_pkg;
    localparam int CLK_MHZ = 250;

    // Bus timing of the flash pins, in ns (window in us) and derived cycles
    localparam int T_SETUP_NS = 10;
    localparam int T_WP_NS    = 35;
    localparam int T_WPH_NS   = 30;
    localparam int T_ACC_NS   = 70;
    localparam int T_BUSY_NS  = 90;
    localparam int T_RP_NS    = 500;
    localparam int T_RH_NS    = 50;
    localparam int SECT_WIN_US = 50;
    localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] WP_CYC    = 8'((T_WP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] WPH_CYC   = 8'((T_WPH_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] ACC_CYC   = 8'((T_ACC_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] BUSY_CYC  = 8'((T_BUSY_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] RP_CYC    = 8'((T_RP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] RH_CYC    = 8'((T_RH_NS * CLK_MHZ + 999) / 1000);
    // Longest time, an exact cycle count
    localparam logic [15:0] SECT_WIN_CYC = 16'(SECT_WIN_US * CLK_MHZ);

    // Register byte offsets
    localparam logic [7:0] REG_CMD    = 8'h00;
    localparam logic [7:0] REG_ADDR   = 8'h04;
    localparam logic [7:0] REG_WDATA  = 8'h08;
    localparam logic [7:0] REG_CFG    = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;
    localparam logic [7:0] REG_RDATA  = 8'h14;

    // Status bit positions
    localparam int ST_ENG_BUSY = 0;
    localparam int ST_DONE     = 1;
    localparam int ST_REFUSED  = 2;
    localparam int ST_READY    = 3;
    localparam int ST_WINDOW   = 4;
    localparam int ST_AUTOSEL  = 5;
    localparam int ST_SECURED  = 6;
    localparam int ST_BYPASS   = 7;

    // Command data values on the flash bus
    localparam logic [15:0] D_UNLOCK1  = 16'h00AA;
    localparam logic [15:0] D_UNLOCK2  = 16'h0055;
    localparam logic [15:0] D_RESET    = 16'h00F0;
    localparam logic [15:0] D_AUTOSEL  = 16'h0090;
    localparam logic [15:0] D_SEC_ENT  = 16'h0088;
    localparam logic [15:0] D_SEC_EXIT = 16'h0000;
    localparam logic [15:0] D_PROG     = 16'h00A0;
    localparam logic [15:0] D_BYPASS   = 16'h0020;
    localparam logic [15:0] D_BYP_X1   = 16'h0090;
    localparam logic [15:0] D_BYP_X2   = 16'h0000;
    localparam logic [15:0] D_ERASE_SU = 16'h0080;
    localparam logic [15:0] D_CHIP_ER  = 16'h0010;
    localparam logic [15:0] D_SECT_ER  = 16'h0030;

    // Unlock addresses in word and byte width
    localparam logic [20:0] A_W1 = 21'h000555;
    localparam logic [20:0] A_W2 = 21'h0002AA;
    localparam logic [20:0] A_B1 = 21'h000AAA;
    localparam logic [20:0] A_B2 = 21'h000555;

    typedef enum logic [3:0] {
        OP_READ       = 4'h0,
        OP_RESET      = 4'h1,
        OP_AUTOSEL    = 4'h2,
        OP_SEC_ENTER  = 4'h3,
        OP_SEC_EXIT   = 4'h4,
        OP_PROGRAM    = 4'h5,
        OP_BYP_ENTER  = 4'h6,
        OP_BYP_PROG   = 4'h7,
        OP_BYP_EXIT   = 4'h8,
        OP_CHIP_ERASE = 4'h9,
        OP_SECT_ERASE = 4'hA,
        OP_SECT_ADD   = 4'hB,
        OP_WAIT       = 4'hC,
        OP_HW_RESET   = 4'hD
    } fcs_op_t;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_SETUP = 3'b001,
        S_WSTB  = 3'b010,
        S_RSTB  = 3'b011,
        S_HOLD  = 3'b100,
        S_PDLY  = 3'b101,
        S_POLL  = 3'b110,
        S_HRST  = 3'b111
    } fcs_state_t;

    typedef struct packed {
        logic        reset_n;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        byte_n;
        logic [20:0] addr;
        logic [15:0] dq_o;
        logic        dq_oe;
    } fcs_pins_t;

    typedef struct packed {
        logic        rd;
        logic [20:0] a;
        logic [15:0] d;
    } fcs_cyc_t;
endpackage

// ### rtl/fcs_host.sv
// Host controller that drives a parallel NOR flash by command sequences
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module fcs_host #(
    parameter logic [15:0] SECT_WIN_CYC = fcs_pkg::SECT_WIN_CYC
) (
    input  wire logic              CLOCK,     // System clock
    input  wire logic              RESET,     // Async reset, high
    input  wire logic              WB_CYC_I,  // Wishbone cycle
    input  wire logic              WB_STB_I,  // Wishbone strobe
    input  wire logic              WB_WE_I,   // Wishbone write
    input  wire logic [7:0]        WB_ADR_I,  // Byte address
    input  wire logic [3:0]        WB_SEL_I,  // Byte enables
    input  wire logic [31:0]       WB_DAT_I,  // Write data
    output logic      [31:0]       WB_DAT_O,  // Read data
    output logic                   WB_ACK_O,  // Acknowledge
    output fcs_pkg::fcs_pins_t     FL_OUT,    // Flash pin drive
    input  wire logic [15:0]       FL_DQ_I,   // Flash data in
    input  wire logic              FL_RY_N    // Flash ready/busy, low busy
);
    fcs_pkg::fcs_state_t st_r, st_nxt;
    fcs_pkg::fcs_op_t    op_r, op_nxt, op_req;
    fcs_pkg::fcs_pins_t  pins_r, pins_nxt;
    fcs_pkg::fcs_cyc_t   cur;
    logic [7:0]  cnt_r, cnt_nxt;
    logic [2:0]  idx_r, idx_nxt;
    logic [20:0] addr_r;
    logic [15:0] wdata_r, rdata_r;
    logic        byte_r, done_r, ref_r, win_r, auto_r, sec_r, byp_r;
    logic [15:0] wcnt_r;
    logic        ack_r;
    logic [31:0] dat_r;

    // One cycle of a sequence: unlock pattern chosen by bus width
    function automatic fcs_pkg::fcs_cyc_t seq_cycle(
        input fcs_pkg::fcs_op_t op, input logic [2:0] i,
        input logic bm, input logic [20:0] a, input logic [15:0] d);
        fcs_pkg::fcs_cyc_t c;
        logic [20:0] u1;
        logic [20:0] u2;
        u1 = bm ? fcs_pkg::A_B1 : fcs_pkg::A_W1;
        u2 = bm ? fcs_pkg::A_B2 : fcs_pkg::A_W2;
        c = '{rd: 1'b0, a: u1, d: fcs_pkg::D_UNLOCK1};
        if (i == 3'd1 || i == 3'd4) begin
            c.a = u2;
            c.d = fcs_pkg::D_UNLOCK2;
        end
        case (op)
            fcs_pkg::OP_READ: c = '{rd: 1'b1, a: a, d: d};
            fcs_pkg::OP_RESET: c = '{rd: 1'b0, a: a, d: fcs_pkg::D_RESET};
            fcs_pkg::OP_AUTOSEL: if (i == 3'd2) c.d = fcs_pkg::D_AUTOSEL;
            fcs_pkg::OP_SEC_ENTER: if (i == 3'd2) c.d = fcs_pkg::D_SEC_ENT;
            fcs_pkg::OP_SEC_EXIT: begin
                if (i == 3'd2) c.d = fcs_pkg::D_AUTOSEL;
                if (i == 3'd3) c = '{rd: 1'b0, a: a, d: fcs_pkg::D_SEC_EXIT};
            end
            fcs_pkg::OP_PROGRAM: begin
                if (i == 3'd2) c.d = fcs_pkg::D_PROG;
                if (i == 3'd3) c = '{rd: 1'b0, a: a, d: d};
            end
            fcs_pkg::OP_BYP_ENTER: if (i == 3'd2) c.d = fcs_pkg::D_BYPASS;
            fcs_pkg::OP_BYP_PROG: begin
                c = '{rd: 1'b0, a: a, d: fcs_pkg::D_PROG};
                if (i == 3'd1) c.d = d;
            end
            fcs_pkg::OP_BYP_EXIT: begin
                c = '{rd: 1'b0, a: a, d: fcs_pkg::D_BYP_X1};
                if (i == 3'd1) c.d = fcs_pkg::D_BYP_X2;
            end
            fcs_pkg::OP_CHIP_ERASE: begin
                if (i == 3'd2) c.d = fcs_pkg::D_ERASE_SU;
                if (i == 3'd5) c.d = fcs_pkg::D_CHIP_ER;
            end
            fcs_pkg::OP_SECT_ERASE: begin
                if (i == 3'd2) c.d = fcs_pkg::D_ERASE_SU;
                if (i == 3'd5) c = '{rd: 1'b0, a: a, d: fcs_pkg::D_SECT_ER};
            end
            fcs_pkg::OP_SECT_ADD: c = '{rd: 1'b0, a: a, d: fcs_pkg::D_SECT_ER};
            default: c = '{rd: 1'b1, a: a, d: d};
        endcase
        return c;
    endfunction

    function automatic logic [2:0] seq_len(input fcs_pkg::fcs_op_t op);
        case (op)
            fcs_pkg::OP_AUTOSEL, fcs_pkg::OP_SEC_ENTER,
            fcs_pkg::OP_BYP_ENTER:                       return 3'd3;
            fcs_pkg::OP_SEC_EXIT, fcs_pkg::OP_PROGRAM:   return 3'd4;
            fcs_pkg::OP_BYP_PROG, fcs_pkg::OP_BYP_EXIT:  return 3'd2;
            fcs_pkg::OP_CHIP_ERASE, fcs_pkg::OP_SECT_ERASE: return 3'd6;
            default:                                     return 3'd1;
        endcase
    endfunction

    // Bus decode
    wire        wb_req   = WB_CYC_I & WB_STB_I & ~ack_r;
    wire        wb_wr    = wb_req & WB_WE_I;
    wire        wr_cmd   = wb_wr & (WB_ADR_I == fcs_pkg::REG_CMD) & WB_SEL_I[0];
    wire        wr_addr  = wb_wr & (WB_ADR_I == fcs_pkg::REG_ADDR);
    wire        wr_wdata = wb_wr & (WB_ADR_I == fcs_pkg::REG_WDATA);
    wire        wr_cfg   = wb_wr & (WB_ADR_I == fcs_pkg::REG_CFG) & WB_SEL_I[0];
    wire        wr_stat  = wb_wr & (WB_ADR_I == fcs_pkg::REG_STATUS) & WB_SEL_I[0];
    assign op_req = fcs_pkg::fcs_op_t'(WB_DAT_I[3:0]);

    // Operation admission
    wire is_pass  = (op_req == fcs_pkg::OP_READ) | (op_req == fcs_pkg::OP_WAIT)
                  | (op_req == fcs_pkg::OP_HW_RESET);
    wire is_byp   = (op_req == fcs_pkg::OP_BYP_PROG)
                  | (op_req == fcs_pkg::OP_BYP_EXIT);
    wire op_known = op_req <= fcs_pkg::OP_HW_RESET;
    wire dev_busy = ~FL_RY_N & ~win_r;
    // bypass mode admits only its own pair besides read, wait and hardware reset
    wire byp_ok   = byp_r ? is_byp : ~is_byp;
    // no bypass in serial number region
    wire sec_ok   = ~((op_req == fcs_pkg::OP_BYP_ENTER) & sec_r);
    wire add_ok   = ~((op_req == fcs_pkg::OP_SECT_ADD) & ~win_r);
    wire legal    = op_known & (is_pass | (~dev_busy & byp_ok & sec_ok & add_ok));
    wire eng_idle = st_r == fcs_pkg::S_IDLE;
    wire start    = wr_cmd & eng_idle & legal;
    wire refuse   = wr_cmd & ~(eng_idle & legal);

    wire [2:0] len      = seq_len(op_r);
    wire       last     = (idx_r + 3'd1) == len;
    wire       cnt_zero = cnt_r == 8'h00;
    wire       poll_op  = (op_r == fcs_pkg::OP_PROGRAM)
                        | (op_r == fcs_pkg::OP_BYP_PROG)
                        | (op_r == fcs_pkg::OP_CHIP_ERASE);
    wire       sect_op  = (op_r == fcs_pkg::OP_SECT_ERASE)
                        | (op_r == fcs_pkg::OP_SECT_ADD);
    wire       finish   = ((st_r == fcs_pkg::S_HOLD) & cnt_zero & last & ~poll_op)
                        | ((st_r == fcs_pkg::S_POLL) & FL_RY_N);
    // window opens at the last strobe rise
    wire       win_open = (st_r == fcs_pkg::S_WSTB) & cnt_zero & last & sect_op;
    wire       win_end  = win_r & (wcnt_r == SECT_WIN_CYC - 16'd1);
    wire       win_kill = start & ~is_pass & (op_req != fcs_pkg::OP_SECT_ADD);
    wire       rd_op    = op_r == fcs_pkg::OP_READ;

    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_zero ? 8'h00 : cnt_r - 8'd1;
        idx_nxt = idx_r;
        op_nxt  = op_r;
        case (st_r)
            fcs_pkg::S_IDLE: if (start) begin
                op_nxt  = op_req;
                idx_nxt = 3'd0;
                st_nxt  = fcs_pkg::S_SETUP;
                cnt_nxt = fcs_pkg::SETUP_CYC - 8'd1;
                if (op_req == fcs_pkg::OP_WAIT) begin
                    st_nxt  = fcs_pkg::S_PDLY;
                    cnt_nxt = fcs_pkg::BUSY_CYC - 8'd1;
                end
                if (op_req == fcs_pkg::OP_HW_RESET) begin
                    st_nxt  = fcs_pkg::S_HRST;
                    cnt_nxt = fcs_pkg::RP_CYC - 8'd1;
                end
            end
            // address settles before the strobe falls
            fcs_pkg::S_SETUP: if (cnt_zero) begin
                st_nxt  = rd_op ? fcs_pkg::S_RSTB : fcs_pkg::S_WSTB;
                cnt_nxt = (rd_op ? fcs_pkg::ACC_CYC : fcs_pkg::WP_CYC) - 8'd1;
            end
            fcs_pkg::S_WSTB, fcs_pkg::S_RSTB: if (cnt_zero) begin
                st_nxt  = fcs_pkg::S_HOLD;
                cnt_nxt = fcs_pkg::WPH_CYC - 8'd1;
            end
            fcs_pkg::S_HOLD: if (cnt_zero) begin
                st_nxt = fcs_pkg::S_IDLE;
                if (!last) begin
                    idx_nxt = idx_r + 3'd1;
                    st_nxt  = fcs_pkg::S_SETUP;
                    cnt_nxt = fcs_pkg::SETUP_CYC - 8'd1;
                end else if (poll_op) begin
                    st_nxt  = fcs_pkg::S_PDLY;
                    cnt_nxt = fcs_pkg::BUSY_CYC - 8'd1;
                end
            end
            // wait out the busy pin rise delay
            fcs_pkg::S_PDLY: if (cnt_zero) st_nxt = fcs_pkg::S_POLL;
            fcs_pkg::S_POLL: if (FL_RY_N) st_nxt = fcs_pkg::S_IDLE;
            fcs_pkg::S_HRST: if (cnt_zero) begin
                st_nxt  = fcs_pkg::S_HOLD;
                cnt_nxt = fcs_pkg::RH_CYC - 8'd1;
            end
            default: st_nxt = fcs_pkg::S_IDLE;
        endcase
    end

    assign cur = seq_cycle(op_nxt, idx_nxt, byte_r, addr_r, wdata_r);

    // Pins follow the next state so they leave flip-flops
    wire in_cyc = (st_nxt == fcs_pkg::S_SETUP) | (st_nxt == fcs_pkg::S_WSTB)
                | (st_nxt == fcs_pkg::S_RSTB);
    assign pins_nxt = '{
        reset_n: st_nxt != fcs_pkg::S_HRST,
        ce_n:    ~in_cyc,
        oe_n:    st_nxt != fcs_pkg::S_RSTB,
        we_n:    st_nxt != fcs_pkg::S_WSTB,
        byte_n:  ~byte_r,
        addr:    cur.a,
        dq_o:    cur.d,
        dq_oe:   in_cyc & ~cur.rd
    };

    wire [31:0] status = {24'h000000, byp_r, sec_r, auto_r, win_r, FL_RY_N,
                          ref_r, done_r, ~eng_idle};
    wire [31:0] rd_mux =
        (WB_ADR_I == fcs_pkg::REG_ADDR)   ? {11'h000, addr_r} :
        (WB_ADR_I == fcs_pkg::REG_WDATA)  ? {16'h0000, wdata_r} :
        (WB_ADR_I == fcs_pkg::REG_CFG)    ? {31'h00000000, byte_r} :
        (WB_ADR_I == fcs_pkg::REG_STATUS) ? status :
        (WB_ADR_I == fcs_pkg::REG_RDATA)  ? {16'h0000, rdata_r} : 32'h00000000;

    wire [20:0] addr_wr = {WB_SEL_I[2] ? WB_DAT_I[20:16] : addr_r[20:16],
                           WB_SEL_I[1] ? WB_DAT_I[15:8]  : addr_r[15:8],
                           WB_SEL_I[0] ? WB_DAT_I[7:0]   : addr_r[7:0]};
    wire [15:0] wd_wr   = {WB_SEL_I[1] ? WB_DAT_I[15:8] : wdata_r[15:8],
                           WB_SEL_I[0] ? WB_DAT_I[7:0]  : wdata_r[7:0]};
    wire        hwr_fin = finish & (op_r == fcs_pkg::OP_HW_RESET);
    wire        cap_rd  = (st_r == fcs_pkg::S_RSTB) & cnt_zero;

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            st_r <= fcs_pkg::S_IDLE;
            op_r <= fcs_pkg::OP_READ;
            cnt_r <= 8'h00;
            idx_r <= 3'd0;
            pins_r <= '{reset_n: 1'b1, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                        byte_n: 1'b1, addr: 21'h000000, dq_o: 16'h0000,
                        dq_oe: 1'b0};
        end else begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            cnt_r <= cnt_nxt;
            idx_r <= idx_nxt;
            pins_r <= pins_nxt;
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            addr_r <= 21'h000000;
            wdata_r <= 16'h0000;
            rdata_r <= 16'h0000;
            byte_r <= 1'b0;
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end else begin
            ack_r <= wb_req;
            if (wb_req) dat_r <= rd_mux;
            if (wr_addr) addr_r <= addr_wr;
            if (wr_wdata) wdata_r <= wd_wr;
            if (wr_cfg) byte_r <= WB_DAT_I[0];
            // read value lands here, incl. status bits
            if (cap_rd) rdata_r <= FL_DQ_I;
        end
    end

    // Sticky flags: a set in the clearing cycle wins
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            done_r <= 1'b0;
            ref_r <= 1'b0;
        end else begin
            done_r <= finish | (done_r & ~(wr_stat & WB_DAT_I[fcs_pkg::ST_DONE]));
            ref_r <= refuse | (ref_r & ~(wr_stat & WB_DAT_I[fcs_pkg::ST_REFUSED]));
        end
    end

    // Window timer; the host refuses additions once it runs out
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            win_r <= 1'b0;
            wcnt_r <= 16'h0000;
        end else begin
            wcnt_r <= (win_open | ~win_r) ? 16'h0000 : wcnt_r + 16'd1;
            if (win_open) win_r <= 1'b1;
            else if (win_end | win_kill | hwr_fin) win_r <= 1'b0;
        end
    end

    // Mode shadow of the device, updated when a sequence completes
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            auto_r <= 1'b0;
            sec_r <= 1'b0;
            byp_r <= 1'b0;
        end else if (finish) begin
            if (op_r == fcs_pkg::OP_AUTOSEL) auto_r <= 1'b1;
            if (op_r == fcs_pkg::OP_RESET || hwr_fin) auto_r <= 1'b0;
            if (op_r == fcs_pkg::OP_SEC_ENTER) sec_r <= 1'b1;
            if (op_r == fcs_pkg::OP_SEC_EXIT || hwr_fin) sec_r <= 1'b0;
            if (op_r == fcs_pkg::OP_BYP_ENTER) byp_r <= 1'b1;
            if (op_r == fcs_pkg::OP_BYP_EXIT || hwr_fin) byp_r <= 1'b0;
        end
    end

    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_r;
    assign FL_OUT   = pins_r;
endmodule // fcs_host

// ### verif/fcs_checker.sv
// Bus and flash pin checks bound to the flash host
`timescale 1ns/1ps
module fcs_checker #(
    parameter logic [15:0] SECT_WIN_CYC = 16'h00C8
) (
    input wire logic               CLOCK,    // Clock
    input wire logic               RESET,    // Reset
    input wire logic               WB_CYC_I, // Cycle
    input wire logic               WB_STB_I, // Strobe
    input wire logic               WB_WE_I,  // Write
    input wire logic [7:0]         WB_ADR_I, // Address
    input wire logic [3:0]         WB_SEL_I, // Lanes
    input wire logic [31:0]        WB_DAT_I, // Write data
    input wire logic [31:0]        WB_DAT_O, // Read data
    input wire logic               WB_ACK_O, // Ack
    input wire fcs_pkg::fcs_pins_t FL_OUT,   // Pins
    input wire logic [15:0]        FL_DQ_I,  // Flash data
    input wire logic               FL_RY_N   // Ready
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RESET);
    // Low time of the write strobe, judged when it rises again
    logic [7:0] wp_cnt;
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            wp_cnt <= 8'h00;
        end else begin
            wp_cnt <= FL_OUT.we_n ? 8'h00 : wp_cnt + 8'd1;
        end
    end
    property p_ack_take;
        WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
    endproperty
    a_ack_take: assert property (p_ack_take) else $error("ack missing");
    property p_ack_one;
        WB_ACK_O |=> !WB_ACK_O && $past(WB_CYC_I && WB_STB_I);
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_wr_stable;
        !FL_OUT.we_n && $past(!FL_OUT.we_n) |-> $stable(FL_OUT.addr)
            && $stable(FL_OUT.dq_o) && FL_OUT.dq_oe && !FL_OUT.ce_n;
    endproperty
    a_wr_stable: assert property (p_wr_stable) else $error("strobe moved");
    property p_wp_len;
        $rose(FL_OUT.we_n) |-> wp_cnt == fcs_pkg::WP_CYC;
    endproperty
    a_wp_len: assert property (p_wp_len) else $error("write pulse width");
    property p_hold;
        $rose(FL_OUT.we_n) |-> (FL_OUT.ce_n && !FL_OUT.dq_oe)[*8];
    endproperty
    a_hold: assert property (p_hold) else $error("write hold short");
    property p_no_fight;
        !FL_OUT.oe_n |-> !FL_OUT.dq_oe && FL_OUT.we_n;
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("bus fight");
    property p_rd_pulse;
        $fell(FL_OUT.oe_n) |-> (!FL_OUT.oe_n && !FL_OUT.ce_n)[*8];
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse short");
    property p_hw_rst;
        $fell(FL_OUT.reset_n) |-> (!FL_OUT.reset_n && FL_OUT.we_n)[*8];
    endproperty
    a_hw_rst: assert property (p_hw_rst) else $error("reset pulse short");
endmodule // fcs_checker

bind fcs_host fcs_checker #(.SECT_WIN_CYC(SECT_WIN_CYC)) u_chk (
    .CLOCK(CLOCK), .RESET(RESET), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .FL_OUT(FL_OUT), .FL_DQ_I(FL_DQ_I), .FL_RY_N(FL_RY_N));

// ### verif/fcs_flash_model.sv
// Behavioural parallel NOR flash answering command cycles
`timescale 1ns/1ps
module fcs_flash_model #(
    parameter logic [15:0] MAKER_ID = 16'h0001, // Arbitrary
    parameter logic [15:0] PART_ID  = 16'h0002, // Arbitrary
    parameter int          BUSY_NS  = 1000      // Embedded op time
) (
    input  wire fcs_pkg::fcs_pins_t pins, // Host drive
    output logic [15:0]             dq,   // Data to host
    output logic                    ry_n  // Ready, low busy
);
    logic [15:0] mem [16];
    logic [15:0] last = 16'h0000;
    logic [2:0]  stp = 3'h0;
    logic [1:0]  mode = 2'h0; // Array, ident, serial, bypass
    logic        ce_l = 1'b0;
    wire         rd = !pins.ce_n && !pins.oe_n;
    wire  [7:0]  lo = pins.addr[7:0];
    // unlock addresses follow the width pin
    wire  [20:0] ua = pins.byte_n ? 21'h555 : 21'hAAA;
    wire  [20:0] ub = pins.byte_n ? 21'h2AA : 21'h555;
    wire  [15:0] val;
    initial begin
        foreach (mem[i]) mem[i] = 16'hFFFF;
        ry_n = 1'b1;
    end
    assign val = mode == 2'h2 ? {12'h5A0, pins.addr[3:0]}
               : mode != 2'h1 ? mem[pins.addr[3:0]]
               : lo == 8'h00 ? MAKER_ID : lo == 8'h01 ? PART_ID : 16'h0000;
    // Released bus shows the inverse, never a held value
    assign dq = rd ? val : ~last;
    always @(*) if (rd) last = val;
    task automatic busy();
        ry_n = 1'b0;
        #(BUSY_NS) ry_n = 1'b1;
    endtask
    task automatic step(input logic [20:0] a, input logic [15:0] d);
        logic u1, u2;
        u1 = a == ua && d == 16'h00AA;
        u2 = a == ub && d == 16'h0055;
        // bypass takes only program and exit
        if (mode == 2'h3 && stp == 3'h0) begin
            stp = d == 16'h00A0 ? 3'h3 : d == 16'h0090 ? 3'h7 : 3'h0;
        end else if (stp == 3'h3) begin
            mem[a[3:0]] &= d;
            stp = 3'h0;
            busy();
        end else if (stp == 3'h7) begin
            mode = d == 16'h0000 ? 2'h0 : mode;
            stp = 3'h0;
        end else if (stp == 3'h2 && a == ua) begin
            stp = d == 16'h00A0 ? 3'h3 : d == 16'h0080 ? 3'h4
                : d == 16'h0090 && mode == 2'h2 ? 3'h7 : 3'h0;
            mode = d == 16'h0088 ? 2'h2 : mode == 2'h2 ? mode
                 : d == 16'h0090 ? 2'h1 : d == 16'h0020 ? 2'h3 : mode;
        end else if (stp == 3'h6) begin
            foreach (mem[i]) if (d == 16'h0010 || i == a[3:0]) mem[i] = 16'hFFFF;
            stp = 3'h0;
            busy();
        // unlocks advance, others back to reads
        end else begin
            stp = (stp == 3'h0 || stp == 3'h4) && u1 ? stp + 3'h1
                : (stp == 3'h1 || stp == 3'h5) && u2 ? stp + 3'h1 : 3'h0;
            mode = d == 16'h00F0 && mode == 2'h1 ? 2'h0 : mode;
        end
    endtask
    always @(negedge pins.we_n) ce_l = !pins.ce_n;
    // data at strobe rise, ignored while busy
    always @(posedge pins.we_n) if (ce_l && ry_n && pins.reset_n) step(pins.addr, pins.dq_o);
endmodule // fcs_flash_model

// ### verif/fcs_host_tb_top.sv
// Self-checking bench of the flash host against a behavioural flash
`timescale 1ns/1ps
module fcs_host_tb_top;
    localparam logic [15:0] MAKER = 16'h00A1; // Arbitrary
    localparam logic [15:0] PART  = 16'h1B2C; // Arbitrary
    logic               clk = 0, rst = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0]         adr = 8'h00;
    logic [31:0]        dat = 32'h0, q, st, rdat;
    logic [15:0]        dq;
    logic               ack, ry_n;
    fcs_pkg::fcs_pins_t pins;
    int                 error_cnt = 0, total_checks = 0;
    always #2 clk = ~clk;
    fcs_host #(.SECT_WIN_CYC(16'h00C8)) uut (.CLOCK(clk), .RESET(rst),
        .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .FL_OUT(pins), .FL_DQ_I(dq), .FL_RY_N(ry_n));
    fcs_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) u_flash (
        .pins(pins), .dq(dq), .ry_n(ry_n));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            chk("bus ack", 32'h1, 32'h0);
            stop_test();
        end
    endtask
    // Issue one op, wait for done or refused, then clear both
    task automatic op(input logic [3:0] c, input logic [20:0] a, input logic [15:0] d);
        int n;
        wb(1'b1, fcs_pkg::REG_ADDR, 32'(a));
        wb(1'b1, fcs_pkg::REG_WDATA, 32'(d));
        wb(1'b1, fcs_pkg::REG_CMD, 32'(c));
        n = 0;
        do begin
            wb(1'b0, fcs_pkg::REG_STATUS, 32'h0);
            n++;
        end while (q[2:1] === 2'b00 && n < 800);
        st = q;
        wb(1'b1, fcs_pkg::REG_STATUS, 32'h6);
        if (n >= 800) begin
            chk("op finish", 32'h1, 32'h0);
            stop_test();
        end
    endtask
    task automatic rdf(input logic [20:0] a, input logic [15:0] e, input string nm);
        op(4'h0, a, 16'h0000);
        wb(1'b0, fcs_pkg::REG_RDATA, 32'h0);
        chk(nm, 32'(e), q);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, q);
        wb(1'b0, fcs_pkg::REG_STATUS, 32'h0);
        chk("status reset", 32'h0, q & 32'hF7);
        $display("test reset done");
        op(4'h2, 21'h0, 16'h0000);
        chk("ident mode", 32'h20, st & 32'h20);
        rdf(21'h000100, MAKER, "maker");
        rdf(21'h000201, PART, "part");
        rdf(21'h010002, 16'h0000, "protect");
        op(4'h1, 21'h0, 16'h0000);
        rdf(21'h000000, 16'hFFFF, "array after reset");
        wb(1'b1, fcs_pkg::REG_CFG, 32'h1);
        op(4'h2, 21'h0, 16'h0000);
        rdf(21'h000100, MAKER, "byte maker");
        op(4'h1, 21'h0, 16'h0000);
        wb(1'b1, fcs_pkg::REG_CFG, 32'h0);
        $display("test ident done");
        op(4'h5, 21'h3, 16'h1234);
        rdf(21'h3, 16'h1234, "program");
        op(4'h5, 21'h3, 16'h00FF);
        rdf(21'h3, 16'h0034, "clear only");
        $display("test program done");
        op(4'h6, 21'h0, 16'h0000);
        chk("bypass mode", 32'h80, st & 32'h80);
        op(4'h7, 21'h4, 16'h0F0F);
        op(4'h7, 21'h5, 16'h3C3C);
        rdf(21'h4, 16'h0F0F, "bypass prog 1");
        rdf(21'h5, 16'h3C3C, "bypass prog 2");
        op(4'h5, 21'h6, 16'h0000);
        chk("refused in bypass", 32'h4, st & 32'h4);
        op(4'h8, 21'h0, 16'h0000);
        chk("bypass exit", 32'h0, st & 32'h80);
        $display("test bypass done");
        op(4'h3, 21'h0, 16'h0000);
        rdf(21'h7, 16'h5A07, "serial read");
        op(4'h6, 21'h0, 16'h0000);
        chk("no bypass in serial", 32'h4, st & 32'h84);
        op(4'h4, 21'h0, 16'h0000);
        rdf(21'h7, 16'hFFFF, "serial exit");
        $display("test serial done");
        op(4'h9, 21'h0, 16'h0000);
        rdf(21'h3, 16'hFFFF, "chip erase");
        op(4'hA, 21'h10000, 16'h0000);
        chk("window open", 32'h10, st & 32'h10);
        op(4'hB, 21'h20000, 16'h0000);
        chk("sector add", 32'h2, st & 32'h6);
        op(4'hC, 21'h0, 16'h0000);
        // Window length set at instantiation
        repeat (210) @(posedge clk);
        op(4'hB, 21'h30000, 16'h0000);
        chk("add after window", 32'h4, st & 32'h14);
        op(4'hD, 21'h0, 16'h0000);
        chk("hw reset", 32'h2, st & 32'h6);
        $display("test erase done");
        stop_test();
    end
endmodule // fcs_host_tb_top
